// *** hdl/reset_ctrl_defs.vh ***
// Offsets, field positions, encodings and cycle counts of the reset controller
`ifndef RESET_CTRL_DEFS_VH
`define RESET_CTRL_DEFS_VH

// ==========================================================
// Register byte offsets
`define OFF_CONTROL 8'h00
`define OFF_STATUS 8'h04
`define OFF_MODE 8'h08

// ==========================================================
// Field positions
`define KEY_HI 31
`define KEY_LO 24
`define KEY_VALUE 8'hA5
`define CR_CPU_BIT 0
`define CR_PERIPH_BIT 2
`define CR_PIN_BIT 3
`define SR_FALL_BIT 0
`define SR_CAUSE_HI 10
`define SR_CAUSE_LO 8
`define SR_LEVEL_BIT 16
`define SR_BUSY_BIT 17
`define MR_UREN_BIT 0
`define MR_IRQEN_BIT 4
`define MR_LEN_HI 11
`define MR_LEN_LO 8

// ==========================================================
// Reset causes and reset values
`define CAUSE_GENERAL 3'h0
`define CAUSE_WAKEUP 3'h1
`define CAUSE_WATCHDOG 3'h2
`define CAUSE_SOFTWARE 3'h3
`define CAUSE_USER 3'h4
`define MODE_RESET_LEN 4'h0

// ==========================================================
// Cycle counts
`define CPU_START_CYCLES 2'h3
`define SW_RESET_CYCLES 2'h3
`define BOOT_SAMPLE_DELAY 3

// ==========================================================
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** hdl/system_reset_controller.v ***
// Reset sequencer with cause recording, pin pulse shaping and AXI4-Lite registers
// Functional notes
// - Sequencing on slow clock, four active-low resets.
// - Mode register survives all but backup loss.
// - Low pin causes user reset only if enabled.
// - Software can always read sampled pin level.
// - Pin fall sets flag; status read clears.
// - Interrupt enable gives interrupt instead of reset only when user reset off.
// - Pin pulse lasts two to power length+1.
// - Boot select sampled three cycles after core-up.
// - Cause updated only when processor reset releases.
// - General reset: startup, clock, 3 cycles, release.
// - Pin rises two cycles after backup release.
// - Backup supply low asserts every reset immediately.
// - Core resets release no earlier than backup reset.
// - Core down asserts all but backup; wake-up.
// - Wake-up pin pulse uses retained length setting.
// - Core supply falling asserts resets at once.
// - User reset: hold, resync, 3 cycles, cause 4.
// - Resets held while pin externally held low.
// - Software reset three cycles, commands combinable.
// - Commanded resets assert on write, release synchronously.
// - Own pin pulse never causes user reset.
// - Software cause recorded only with processor command.
// - Busy flag blocks control writes during software reset.
// - Cause encoding 0..4, unchanged by status read.
// - Writes need key 0xA5, otherwise aborted.
// - Interrupt on flag when user reset off, enabled.
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "reset_ctrl_defs.vh"

module system_reset_controller #(
    parameter STARTUP_CYCLES = 64,
    parameter STARTUP_W = 16
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Supply detectors and pins
    input wire backup_supply_ok,
    input wire core_supply_ok,
    input wire boot_select_pin,
    input wire pin_reset_in,
    output reg pin_reset_drive_n,
    output reg pin_reset_oe,
    // Reset outputs
    output reg cpu_reset_n,
    output reg periph_reset_n,
    output reg backup_domain_reset_n,
    output reg cpu_clk_en,
    output reg boot_select,
    output reg irq,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    localparam [7:0] S_BACKUP = 8'h01;
    localparam [7:0] S_STARTUP = 8'h02;
    localparam [7:0] S_CORE_OFF = 8'h04;
    localparam [7:0] S_CPU_START = 8'h08;
    localparam [7:0] S_RUN = 8'h10;
    localparam [7:0] S_USER = 8'h20;
    localparam [7:0] S_USER_WAIT = 8'h40;
    localparam [7:0] S_SW = 8'h80;
    localparam [STARTUP_W-1:0] STARTUP_LOAD = STARTUP_CYCLES;

    // ==========================================================
    // Input synchronisers
    reg bk_meta_q, bk_q, co_meta_q, co_q, co_d1_q;
    reg pin_meta_q, pin_q, pin_d1_q, bs_meta_q, bs_q;
    reg [2:0] boot_dly_q;

    always @(posedge core_clk) begin
        bk_meta_q <= backup_supply_ok;
        bk_q <= bk_meta_q;
        co_meta_q <= core_supply_ok;
        co_q <= co_meta_q;
        co_d1_q <= co_q;
        pin_meta_q <= pin_reset_in;
        pin_q <= pin_meta_q;
        pin_d1_q <= pin_q;
        bs_meta_q <= boot_select_pin;
        bs_q <= bs_meta_q;
    end

    // ==========================================================
    // Registers
    reg ur_en_q, ur_irq_en_q, fall_flag_q;
    reg [3:0] len_q;
    reg [2:0] cause_q;
    reg [7:0] state_q, state_d;
    reg [2:0] pend_q, pend_d;
    reg pend_v_q, pend_v_d;
    reg [1:0] cnt_q, cnt_d;
    reg [STARTUP_W-1:0] st_cnt_q;
    reg [16:0] ext_cnt_q;
    reg own_q, sw_cpu_q, sw_per_q;
    reg [7:0] wa_q;
    reg [31:0] wd_q;
    reg [3:0] ws_q;
    reg aw_got_q, w_got_q;

    wire wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;
    wire key_ok = (wd_q[`KEY_HI:`KEY_LO] == `KEY_VALUE) && (ws_q == 4'hF);
    wire cr_hit = wr_fire & (wa_q == `OFF_CONTROL);
    wire mr_hit = wr_fire & (wa_q == `OFF_MODE);
    wire wr_ok = cr_hit | mr_hit | (wr_fire & (wa_q == `OFF_STATUS));
    wire cmd_any = wd_q[`CR_CPU_BIT] | wd_q[`CR_PERIPH_BIT] | wd_q[`CR_PIN_BIT];
    // Control writes while busy or in any reset are dropped
    wire sw_go = cr_hit & key_ok & cmd_any & (state_q == S_RUN);
    wire rd_fire = s_axi_arvalid & s_axi_arready;
    wire sr_read = rd_fire & (s_axi_araddr == `OFF_STATUS);
    wire pin_fall = pin_d1_q & ~pin_q;
    wire ext_busy = (ext_cnt_q != 17'h0);
    wire user_trig = ~pin_q & ur_en_q & ~own_q & ~ext_busy;
    wire [16:0] pulse_len = 17'h1 << ({1'b0, len_q} + 5'h01);
    wire busy = (state_q == S_SW);

    // ==========================================================
    // Reset state manager
    always @* begin
        state_d = state_q;
        pend_d = pend_q;
        pend_v_d = pend_v_q;
        cnt_d = (cnt_q != 2'h0) ? cnt_q - 2'h1 : 2'h0;
        case (state_q)
            S_BACKUP: begin
                state_d = S_STARTUP;
                pend_d = `CAUSE_GENERAL;
                pend_v_d = 1'b1;
            end
            S_STARTUP: begin
                if (st_cnt_q == {STARTUP_W{1'b0}}) begin
                    state_d = co_q ? S_CPU_START : S_CORE_OFF;
                    cnt_d = `CPU_START_CYCLES;
                end
            end
            S_CORE_OFF: begin
                if (co_q) begin
                    state_d = S_CPU_START;
                    cnt_d = `CPU_START_CYCLES;
                end
            end
            S_CPU_START: begin
                if (cnt_q == 2'h1)
                    state_d = S_RUN;
            end
            S_RUN: begin
                if (sw_go) begin
                    state_d = S_SW;
                    cnt_d = `SW_RESET_CYCLES;
                    pend_d = `CAUSE_SOFTWARE;
                    pend_v_d = wd_q[`CR_CPU_BIT];
                end else if (user_trig) begin
                    state_d = S_USER;
                    pend_d = `CAUSE_USER;
                    pend_v_d = 1'b1;
                end
            end
            S_USER: begin
                if (pin_q) begin
                    state_d = S_USER_WAIT;
                    cnt_d = `CPU_START_CYCLES;
                end
            end
            S_USER_WAIT: begin
                if (!pin_q)
                    state_d = S_USER;
                else if (cnt_q == 2'h1)
                    state_d = S_RUN;
            end
            S_SW: begin
                if (cnt_q == 2'h1)
                    state_d = S_RUN;
            end
            default: begin
                state_d = S_BACKUP;
            end
        endcase
        // Core loss is ignored only in the backup, startup and core-off states
        if (!co_q && state_q != S_BACKUP && state_q != S_STARTUP && state_q != S_CORE_OFF) begin
            state_d = S_CORE_OFF;
            pend_d = `CAUSE_WAKEUP;
            pend_v_d = 1'b1;
        end
        if (!bk_q) begin
            state_d = S_BACKUP;
            pend_d = `CAUSE_GENERAL;
            pend_v_d = 1'b1;
        end
    end

    wire gen_hold = (state_d == S_BACKUP) || (state_d == S_STARTUP) ||
                    ((state_d == S_CPU_START || state_d == S_CORE_OFF) &&
                     pend_v_d && pend_d == `CAUSE_GENERAL);
    wire in_por = (state_d == S_BACKUP) || (state_d == S_STARTUP) ||
                  (state_d == S_CORE_OFF) || (state_d == S_CPU_START);
    wire release_por = (state_q == S_CPU_START) && (state_d == S_RUN);
    wire pin_cmd = sw_go & wd_q[`CR_PIN_BIT];
    wire ext_load = release_por | pin_cmd | ((state_q == S_RUN) & (state_d == S_USER));
    // Load edge drives low itself, so the counter holds one cycle less
    wire drive_d = in_por | ext_busy | ext_load;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= S_STARTUP;
            pend_q <= `CAUSE_GENERAL;
            pend_v_q <= 1'b1;
            cnt_q <= 2'h0;
            st_cnt_q <= STARTUP_LOAD;
            cause_q <= `CAUSE_GENERAL;
            ext_cnt_q <= 17'h0;
            own_q <= 1'b1;
            sw_cpu_q <= 1'b0;
            sw_per_q <= 1'b0;
            cpu_reset_n <= 1'b0;
            periph_reset_n <= 1'b0;
            backup_domain_reset_n <= 1'b0;
            cpu_clk_en <= 1'b0;
            pin_reset_drive_n <= 1'b0;
            pin_reset_oe <= 1'b1;
            boot_dly_q <= 3'h0;
            boot_select <= 1'b0;
        end else begin
            state_q <= state_d;
            pend_q <= pend_d;
            pend_v_q <= pend_v_d;
            cnt_q <= cnt_d;
            if (state_d != S_STARTUP)
                st_cnt_q <= STARTUP_LOAD;
            else if (st_cnt_q != {STARTUP_W{1'b0}})
                st_cnt_q <= st_cnt_q - {{(STARTUP_W-1){1'b0}}, 1'b1};
            // Cause only moves on the release edge of the processor reset
            if (state_q != S_RUN && state_d == S_RUN && pend_v_q)
                cause_q <= pend_q;
            // Pulse starts at release so the pin trails backup release
            if (ext_load)
                ext_cnt_q <= pulse_len - 17'h1;
            else if (in_por)
                ext_cnt_q <= 17'h0;
            else if (ext_busy)
                ext_cnt_q <= ext_cnt_q - 17'h1;
            // Mask lasts until our own low has cleared the synchroniser
            if (drive_d)
                own_q <= 1'b1;
            else if (pin_q)
                own_q <= 1'b0;
            if (sw_go) begin
                sw_cpu_q <= wd_q[`CR_CPU_BIT];
                sw_per_q <= wd_q[`CR_PERIPH_BIT];
            end
            cpu_reset_n <= (state_d == S_RUN) || (state_d == S_SW && !sw_go_cpu(sw_go, wd_q, sw_cpu_q));
            periph_reset_n <= (state_d == S_RUN) ||
                              (state_d == S_SW && !(sw_go ? wd_q[`CR_PERIPH_BIT] : sw_per_q));
            backup_domain_reset_n <= !gen_hold;
            cpu_clk_en <= (state_d == S_RUN) || (state_d == S_CPU_START) ||
                          (state_d == S_USER_WAIT) || (state_d == S_SW);
            pin_reset_drive_n <= !drive_d;
            pin_reset_oe <= drive_d;
            boot_dly_q <= {boot_dly_q[1:0], co_q & ~co_d1_q};
            if (boot_dly_q[2])
                boot_select <= bs_q;
        end
    end

    function sw_go_cpu;
        input go;
        input [31:0] wd;
        input held;
        begin
            sw_go_cpu = go ? wd[`CR_CPU_BIT] : held;
        end
    endfunction

    // ==========================================================
    // Mode and status bits
    always @(posedge core_clk) begin
        // Backup-domain register: core loss leaves it alone
        if (sys_rst || !bk_q) begin
            ur_en_q <= 1'b0;
            ur_irq_en_q <= 1'b0;
            len_q <= `MODE_RESET_LEN;
        end else if (mr_hit && key_ok) begin
            ur_en_q <= wd_q[`MR_UREN_BIT];
            ur_irq_en_q <= wd_q[`MR_IRQEN_BIT];
            len_q <= wd_q[`MR_LEN_HI:`MR_LEN_LO];
        end
        if (sys_rst) begin
            fall_flag_q <= 1'b0;
            irq <= 1'b0;
        end else begin
            // An edge in the read cycle survives the clear
            fall_flag_q <= pin_fall | (fall_flag_q & ~sr_read);
            irq <= (pin_fall | (fall_flag_q & ~sr_read)) & ~ur_en_q & ur_irq_en_q;
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    always @(posedge core_clk) begin
        if (sys_rst) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            wa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                wa_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_got_q <= 1'b0;
            end
            s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_got_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid && !rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                case (s_axi_araddr)
                    `OFF_CONTROL: s_axi_rdata <= 32'h0000_0000;
                    `OFF_STATUS: begin
                        s_axi_rdata[`SR_FALL_BIT] <= fall_flag_q;
                        s_axi_rdata[`SR_CAUSE_HI:`SR_CAUSE_LO] <= cause_q;
                        s_axi_rdata[`SR_LEVEL_BIT] <= pin_q;
                        s_axi_rdata[`SR_BUSY_BIT] <= busy;
                    end
                    `OFF_MODE: begin
                        s_axi_rdata[`MR_UREN_BIT] <= ur_en_q;
                        s_axi_rdata[`MR_IRQEN_BIT] <= ur_irq_en_q;
                        s_axi_rdata[`MR_LEN_HI:`MR_LEN_LO] <= len_q;
                    end
                    default: s_axi_rresp <= `RESP_SLVERR;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // system_reset_controller

`default_nettype wire

// *** test/reset_ctrl_props.sv ***
// Port-level assertions for the reset controller
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module reset_ctrl_props #(
    parameter STARTUP_CYCLES = 64,
    parameter STARTUP_W = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Supplies and pin
    input wire logic backup_supply_ok,
    input wire logic core_supply_ok,
    input wire logic pin_reset_drive_n,
    input wire logic pin_reset_oe,
    // Resets
    input wire logic cpu_reset_n,
    input wire logic periph_reset_n,
    input wire logic backup_domain_reset_n,
    input wire logic cpu_clk_en,
    // Bus
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_oe_pair;
        pin_reset_oe == !pin_reset_drive_n;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("pin enable mismatch");
    property p_bu_all;
        !backup_domain_reset_n |-> !cpu_reset_n && !periph_reset_n;
    endproperty
    a_bu_all: assert property (p_bu_all) else $error("backup reset alone");
    property p_bu_low;
        !backup_supply_ok [*4] |-> !backup_domain_reset_n && !pin_reset_drive_n;
    endproperty
    a_bu_low: assert property (p_bu_low) else $error("backup loss ignored");
    property p_core_low;
        !core_supply_ok [*4] |-> !cpu_reset_n && !periph_reset_n;
    endproperty
    a_core_low: assert property (p_core_low) else $error("core loss ignored");
    property p_start;
        $rose(cpu_reset_n) && $rose(periph_reset_n) |-> $past(cpu_clk_en, 1) && $past(cpu_clk_en, 3);
    endproperty
    a_start: assert property (p_start) else $error("release without clock");
    property p_pin_gen;
        $rose(backup_domain_reset_n) |-> ##2 $rose(pin_reset_drive_n);
    endproperty
    a_pin_gen: assert property (p_pin_gen) else $error("pin release timing");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && !(s_axi_araddr inside {8'h00, 8'h04, 8'h08})
            |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answer");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
endmodule // reset_ctrl_props

bind system_reset_controller reset_ctrl_props #(.STARTUP_CYCLES(STARTUP_CYCLES),
    .STARTUP_W(STARTUP_W)) props_u (.core_clk, .sys_rst, .backup_supply_ok, .core_supply_ok,
    .pin_reset_drive_n, .pin_reset_oe, .cpu_reset_n, .periph_reset_n, .backup_domain_reset_n,
    .cpu_clk_en, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// *** test/reset_line_partner.sv ***
// External party on the open-drain reset line
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Line with pull-up
module reset_line_partner (
    // Device side
    input wire logic pin_reset_drive_n,
    input wire logic pin_reset_oe,
    // Bench control
    input wire logic hold_low,
    // Line level
    output logic pin_level
);
    // Released line floats to the pull-up, never to a stale level
    assign pin_level = !((pin_reset_oe && !pin_reset_drive_n) || hold_low);
endmodule // reset_line_partner
`default_nettype wire

// *** test/system_reset_controller_tb.sv ***
// Register-level tests of the reset controller
`timescale 1ns/1ps
`default_nettype none
`include "reset_ctrl_defs.vh"
module system_reset_controller_tb;
    logic core_clk, sys_rst = 1'b1, backup_supply_ok = 1'b1, core_supply_ok = 1'b1;
    logic boot_select_pin = 1'b0, hold_low = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic pin_reset_drive_n, pin_reset_oe, cpu_reset_n, periph_reset_n, irq;
    logic backup_domain_reset_n, cpu_clk_en, boot_select;
    wire pin_reset_in;
    int miscompares = 0, checked = 0, run_len = 0, last_run = 0, gap = 0;

    system_reset_controller #(.STARTUP_CYCLES(8), .STARTUP_W(16)) dut_u (.core_clk, .sys_rst,
        .backup_supply_ok, .core_supply_ok, .boot_select_pin, .pin_reset_in, .pin_reset_drive_n,
        .pin_reset_oe, .cpu_reset_n, .periph_reset_n, .backup_domain_reset_n, .cpu_clk_en,
        .boot_select, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    reset_line_partner line_u (.pin_reset_drive_n, .pin_reset_oe, .hold_low,
        .pin_level(pin_reset_in));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Pulse length, and pin low time after processor release
    always @(posedge core_clk) begin
        if (pin_reset_drive_n === 1'b0) run_len <= run_len + 1;
        else if (run_len != 0) begin
            last_run <= run_len;
            run_len <= 0;
        end
        if (cpu_reset_n !== 1'b1) gap <= 0;
        else if (pin_reset_drive_n === 1'b0) gap <= gap + 1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, da, dw;
        da = 1'b0;
        dw = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(da && dw)) begin
            @(negedge core_clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            da = da || ta;
            dw = dw || tw;
        end
        do @(negedge core_clk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        @(posedge core_clk);
        s_axi_bready <= 1'b0;
        #1;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge core_clk); while (s_axi_arready !== 1'b1);
        @(posedge core_clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge core_clk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge core_clk);
        s_axi_rready <= 1'b0;
        #1;
    endtask
    task automatic wait_up;
        do @(negedge core_clk); while (cpu_reset_n !== 1'b1);
        // Lets the released pin level pass the synchroniser
        cyc(4);
    endtask
    task automatic chk_cause(input logic [2:0] c);
        axi_rd(`OFF_STATUS);
        chk({29'h0, rd[10:8]}, {29'h0, c});
    endtask
    task automatic complete_run;
        if (miscompares == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        complete_run;
    end

    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        wait_up;
        chk_cause(`CAUSE_GENERAL);
        chk({30'h0, rd[17:16]}, 32'h1);
        axi_rd(`OFF_MODE);
        chk(rd & 32'h00FF_FFFF, 32'h0);
        chk(gap, 32'h2);
        axi_rd(8'h0C);
        chk({30'h0, rsp}, 32'h2);
        axi_wr(8'h10, 32'hA500_0001);
        chk({30'h0, rsp}, 32'h2);
        // Wrong key or partial strobes leave mode and processor alone
        axi_wr(`OFF_MODE, 32'h5A00_0101);
        axi_wr(`OFF_CONTROL, 32'h5A00_0001);
        s_axi_wstrb <= 4'h7;
        axi_wr(`OFF_MODE, 32'hA500_0101);
        s_axi_wstrb <= 4'hF;
        axi_rd(`OFF_MODE);
        chk(rd & 32'hFFF, 32'h0);
        chk(32'(cpu_reset_n), 32'h1);
        axi_wr(`OFF_MODE, 32'hA500_0101);
        axi_rd(`OFF_MODE);
        chk(rd & 32'hFFF, 32'h101);
        // Processor-only software reset
        axi_wr(`OFF_CONTROL, 32'hA500_0001);
        chk({30'h0, cpu_reset_n, periph_reset_n}, 32'h1);
        wait_up;
        chk_cause(`CAUSE_SOFTWARE);
        chk(32'(rd[17]), 32'h0);
        // Peripheral and pin commands without processor
        axi_wr(`OFF_CONTROL, 32'hA500_000C);
        chk(32'(periph_reset_n), 32'h0);
        cyc(12);
        chk(last_run, 32'h4);
        chk(32'(cpu_reset_n), 32'h1);
        chk_cause(`CAUSE_SOFTWARE);
        // Line held low well past the pulse
        hold_low <= 1'b1;
        cyc(20);
        chk({30'h0, cpu_reset_n, periph_reset_n}, 32'h0);
        hold_low <= 1'b0;
        cyc(3);
        chk(32'(cpu_reset_n), 32'h0);
        wait_up;
        chk_cause(`CAUSE_USER);
        chk(32'(rd[0]), 32'h1);
        axi_rd(`OFF_STATUS);
        chk(32'(rd[0]), 32'h0);
        // Interrupt instead of user reset
        axi_wr(`OFF_MODE, 32'hA500_0110);
        hold_low <= 1'b1;
        cyc(6);
        hold_low <= 1'b0;
        cyc(6);
        chk({30'h0, irq, cpu_reset_n}, 32'h3);
        axi_rd(`OFF_STATUS);
        chk(32'(rd[0]), 32'h1);
        cyc(1);
        chk(32'(irq), 32'h0);
        // Core supply loss and wake-up
        boot_select_pin <= 1'b1;
        core_supply_ok <= 1'b0;
        cyc(8);
        chk({30'h0, cpu_reset_n, backup_domain_reset_n}, 32'h1);
        core_supply_ok <= 1'b1;
        wait_up;
        chk(32'(boot_select), 32'h1);
        chk_cause(`CAUSE_WAKEUP);
        chk(gap, 32'h4);
        // Backup supply loss clears the mode
        backup_supply_ok <= 1'b0;
        cyc(8);
        chk(32'(backup_domain_reset_n), 32'h0);
        backup_supply_ok <= 1'b1;
        wait_up;
        chk_cause(`CAUSE_GENERAL);
        axi_rd(`OFF_MODE);
        chk(rd & 32'hFFF, 32'h0);
        chk(gap, 32'h2);
        complete_run;
    end
endmodule // system_reset_controller_tb
`default_nettype wire
